// File: design/ets_pkg.sv
// Package: constants, types and register map of the exposure trigger sequencer
package ets_pkg;

  // ==========================================================================
  // Register map (word offsets are byte addresses)
  localparam logic [7:0] ETS_REG_CTRL     = 8'h00;
  localparam logic [7:0] ETS_REG_EXPOSURE = 8'h04;
  localparam logic [7:0] ETS_REG_ROWS     = 8'h08;
  localparam logic [7:0] ETS_REG_ROWTIME  = 8'h0C;
  localparam logic [7:0] ETS_REG_STATUS   = 8'h10;
  localparam logic [7:0] ETS_REG_IRQ_STAT = 8'h14;
  localparam logic [7:0] ETS_REG_IRQ_MASK = 8'h18;
  localparam logic [7:0] ETS_REG_FRAMES   = 8'h1C;

  // ==========================================================================
  // Field positions
  localparam int ETS_CTRL_EN_BIT   = 0;
  localparam int ETS_IRQ_EXP_START = 0;
  localparam int ETS_IRQ_RD_START  = 1;
  localparam int ETS_IRQ_RD_DONE   = 2;
  localparam int ETS_IRQ_DROPPED   = 3;
  localparam int ETS_IRQ_W         = 4;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] ETS_EXPOSURE_RST = 32'h0000_2710;
  localparam logic [15:0] ETS_ROWS_RST     = 16'h01ED;
  localparam logic [15:0] ETS_ROWTIME_RST  = 16'h0028;
  localparam logic [3:0]  ETS_MASK_RST     = 4'h0;

  // ==========================================================================
  // Timing
  localparam int ETS_CLK_MHZ     = 25;
  localparam int ETS_TICK_NS     = 1000;
  localparam int ETS_TICK_CYCLES = (ETS_TICK_NS * ETS_CLK_MHZ) / 1000;

  typedef enum logic [1:0] {
    ETS_EXP_IDLE,
    ETS_EXP_WAIT_ROW,
    ETS_EXP_RUN,
    ETS_EXP_HOLD
  } ets_exp_e;

  typedef struct packed {
    logic exposure;
    logic readout;
    logic imaging;
    logic idle;
    logic trig_ready;
  } ets_status_s;

  // Saturating subtraction, used for the start delay and the readout remaining count
  function automatic logic [31:0] ets_sat_sub(input logic [31:0] a, input logic [31:0] b);
    ets_sat_sub = (a > b) ? (a - b) : 32'h0000_0000;
  endfunction

endpackage

// File: design/ets_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module ets_sync (
  input  wire logic CLK,
  input  wire logic RST,
  input  wire logic din,
  output logic      dout
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  always_ff @(posedge CLK) begin
    if (RST) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      dout  <= 1'b0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        dout <= s3_ff;
      end
    end
  end
endmodule

// File: design/ets_readout.sv
// Sensor readout engine: row timing and row boundary pulses
`timescale 1ns/1ps
module ets_readout
  import ets_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        tick,
  input  wire logic        start,
  input  wire logic [15:0] rows,
  input  wire logic [15:0] row_time,
  output logic             busy,
  output logic             row_edge,
  output logic             done,
  output logic [31:0]      remain
);
  logic [15:0] row_cnt_ff;
  logic [15:0] tick_cnt_ff;
  logic [31:0] remain_ff;
  logic        busy_ff;

  wire row_end  = busy_ff && tick && (tick_cnt_ff + 16'h0001 >= row_time);
  wire last_row = (row_cnt_ff + 16'h0001 >= rows);

  assign busy     = busy_ff;
  assign row_edge = row_end;
  assign done     = row_end && last_row;
  assign remain   = remain_ff;

  always_ff @(posedge CLK) begin
    if (RST) begin
      busy_ff     <= 1'b0;
      row_cnt_ff  <= 16'h0000;
      tick_cnt_ff <= 16'h0000;
      remain_ff   <= 32'h0000_0000;
    end else if (start && (!busy_ff || done)) begin // Restart on last row end
      busy_ff     <= 1'b1;
      row_cnt_ff  <= 16'h0000;
      tick_cnt_ff <= 16'h0000;
      remain_ff   <= 32'(rows) * 32'(row_time);
    end else if (busy_ff && tick) begin
      remain_ff <= ets_sat_sub(remain_ff, 32'h0000_0001);
      if (row_end) begin
        tick_cnt_ff <= 16'h0000;
        row_cnt_ff  <= row_cnt_ff + 16'h0001;
        if (last_row) begin
          busy_ff <= 1'b0;
        end
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 16'h0001;
      end
    end
  end
endmodule

// File: design/ets_top.sv
// Exposure trigger sequencer: trigger to exposure and overlapped readout
// ============================================================================
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module ets_top
  import ets_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        TRIG_IN,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [31:0] RDATA,
  output logic             TRIG_READY,
  output logic             EXPOSURE,
  output logic             READOUT,
  output logic             IMAGING,
  output logic             IDLE,
  output logic             IRQ
);

  // ==========================================================================
  // Registers
  logic        enable_ff;
  logic [31:0] exposure_ff;
  logic [15:0] rows_ff;
  logic [15:0] row_time_ff;
  logic [ETS_IRQ_W-1:0] irq_stat_ff;
  logic [ETS_IRQ_W-1:0] irq_mask_ff;
  logic [31:0] frames_ff;
  logic [31:0] rdata_ff;

  // ==========================================================================
  // Microsecond tick divider
  logic [7:0] div_ff;
  wire        tick = (div_ff == 8'(ETS_TICK_CYCLES - 1));

  always_ff @(posedge CLK) begin
    if (RST || tick) begin
      div_ff <= 8'h00;
    end else begin
      div_ff <= div_ff + 8'h01;
    end
  end

  // ==========================================================================
  // Trigger input, synchronised, rising edge
  logic trig_sync;
  logic trig_prev_ff;

  ets_sync u_sync (
    .CLK  (CLK),
    .RST  (RST),
    .din  (TRIG_IN),
    .dout (trig_sync)
  );

  always_ff @(posedge CLK) begin
    if (RST) begin
      trig_prev_ff <= 1'b0;
    end else begin
      trig_prev_ff <= trig_sync;
    end
  end

  wire trig_edge = trig_sync && !trig_prev_ff;

  // ==========================================================================
  // Readout engine
  logic        ro_busy;
  logic        ro_row_edge;
  logic        ro_done;
  logic [31:0] ro_remain;
  logic        ro_start;

  ets_readout u_readout (
    .CLK      (CLK),
    .RST      (RST),
    .tick     (tick),
    .start    (ro_start),
    .rows     (rows_ff),
    .row_time (row_time_ff),
    .busy     (ro_busy),
    .row_edge (ro_row_edge),
    .done     (ro_done),
    .remain   (ro_remain)
  );

  // ==========================================================================
  // Exposure state machine
  ets_exp_e    state_ff;
  ets_exp_e    nxt_state;
  logic [31:0] exp_cnt_ff;
  logic [31:0] delay_cnt_ff;
  logic        ready_ff;
  logic        armed_ff;

  wire [31:0] readout_len  = 32'(rows_ff) * 32'(row_time_ff);
  wire [31:0] start_delay  = ets_sat_sub(readout_len, exposure_ff);
  wire        exp_time_up  = tick && (exp_cnt_ff + 32'h0000_0001 >= exposure_ff);
  wire        exp_counting = (state_ff == ETS_EXP_RUN);
  wire        accept       = trig_edge && ready_ff && enable_ff;
  wire        row_ok       = !ro_busy || ro_row_edge;
  wire        ro_clear     = !ro_busy || ro_done;
  wire        exp_end      = (state_ff == ETS_EXP_HOLD) && ro_clear;
  wire        exp_start    = (state_ff == ETS_EXP_WAIT_ROW) && row_ok;
  wire        delay_up     = (delay_cnt_ff >= start_delay) && (state_ff == ETS_EXP_IDLE);

  assign ro_start = exp_end;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ETS_EXP_IDLE: begin
        if (accept) begin
          nxt_state = ETS_EXP_WAIT_ROW;
        end
      end
      ETS_EXP_WAIT_ROW: begin
        if (row_ok) begin
          nxt_state = ETS_EXP_RUN;
        end
      end
      ETS_EXP_RUN: begin
        if (exp_time_up || exposure_ff == 32'h0000_0000) begin
          nxt_state = ETS_EXP_HOLD;
        end
      end
      ETS_EXP_HOLD: begin
        if (ro_clear) begin
          nxt_state = ETS_EXP_IDLE;
        end
      end
      default: nxt_state = ETS_EXP_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_ff <= ETS_EXP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST || exp_start) begin
      exp_cnt_ff <= 32'h0000_0000;
    end else if (exp_counting && tick) begin
      exp_cnt_ff <= exp_cnt_ff + 32'h0000_0001;
    end
  end

  // Ready: idle immediately, else after start delay from exposure start
  always_ff @(posedge CLK) begin
    if (RST) begin
      delay_cnt_ff <= 32'h0000_0000;
      armed_ff     <= 1'b0;
      ready_ff     <= 1'b0;
    end else if (accept) begin
      ready_ff <= 1'b0;
      armed_ff <= 1'b0;
    end else if (exp_start) begin
      delay_cnt_ff <= 32'h0000_0000;
      armed_ff     <= 1'b1;
    end else if (armed_ff) begin
      if (delay_up) begin
        ready_ff <= enable_ff;
        armed_ff <= 1'b0;
      end else if (tick) begin
        delay_cnt_ff <= delay_cnt_ff + 32'h0000_0001;
      end
    end else if (state_ff == ETS_EXP_IDLE && !ro_busy) begin
      ready_ff <= enable_ff;
    end
  end

  // ==========================================================================
  // Status outputs
  ets_status_s stat_ff;
  ets_status_s nxt_stat;
  wire         exp_on = (state_ff == ETS_EXP_RUN) || (state_ff == ETS_EXP_HOLD);

  always_comb begin
    nxt_stat.exposure   = exp_on;
    nxt_stat.readout    = ro_busy;
    nxt_stat.imaging    = exp_on || ro_busy;
    nxt_stat.idle       = !(exp_on || ro_busy);
    nxt_stat.trig_ready = ready_ff;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      stat_ff <= '{exposure: 1'b0, readout: 1'b0, imaging: 1'b0, idle: 1'b1,
                   trig_ready: 1'b0};
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // ==========================================================================
  // Register bus
  wire wr_ctrl = WR && (ADDR == ETS_REG_CTRL);
  wire wr_exp  = WR && (ADDR == ETS_REG_EXPOSURE);
  wire wr_rows = WR && (ADDR == ETS_REG_ROWS);
  wire wr_rt   = WR && (ADDR == ETS_REG_ROWTIME);
  wire wr_ist  = WR && (ADDR == ETS_REG_IRQ_STAT);
  wire wr_imk  = WR && (ADDR == ETS_REG_IRQ_MASK);

  wire [ETS_IRQ_W-1:0] irq_evt;
  assign irq_evt[ETS_IRQ_EXP_START] = exp_start;
  assign irq_evt[ETS_IRQ_RD_START]  = ro_start;
  assign irq_evt[ETS_IRQ_RD_DONE]   = ro_done;
  assign irq_evt[ETS_IRQ_DROPPED]   = trig_edge && !accept;

  wire [ETS_IRQ_W-1:0] ist_clr = wr_ist ? WDATA[ETS_IRQ_W-1:0] : '0;
  wire [ETS_IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~ist_clr) | irq_evt;

  wire [31:0] rd_mux =
      (ADDR == ETS_REG_CTRL)     ? {31'h0000_0000, enable_ff} :
      (ADDR == ETS_REG_EXPOSURE) ? exposure_ff :
      (ADDR == ETS_REG_ROWS)     ? {16'h0000, rows_ff} :
      (ADDR == ETS_REG_ROWTIME)  ? {16'h0000, row_time_ff} :
      (ADDR == ETS_REG_STATUS)   ? {27'h000_0000, stat_ff} :
      (ADDR == ETS_REG_IRQ_STAT) ? {28'h000_0000, irq_stat_ff} :
      (ADDR == ETS_REG_IRQ_MASK) ? {28'h000_0000, irq_mask_ff} :
      (ADDR == ETS_REG_FRAMES)   ? frames_ff :
                                   32'h0000_0000;

  always_ff @(posedge CLK) begin
    if (RST) begin
      enable_ff   <= 1'b0;
      exposure_ff <= ETS_EXPOSURE_RST;
      rows_ff     <= ETS_ROWS_RST;
      row_time_ff <= ETS_ROWTIME_RST;
      irq_mask_ff <= ETS_MASK_RST;
    end else begin
      if (wr_ctrl) enable_ff   <= WDATA[ETS_CTRL_EN_BIT];
      if (wr_exp)  exposure_ff <= WDATA;
      if (wr_rows) rows_ff     <= WDATA[15:0];
      if (wr_rt)   row_time_ff <= WDATA[15:0];
      if (wr_imk)  irq_mask_ff <= WDATA[ETS_IRQ_W-1:0];
    end
  end

  // Set wins over clear
  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_stat_ff <= '0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
    end
  end

  // Completed frames, counted at each readout end
  always_ff @(posedge CLK) begin
    if (RST) begin
      frames_ff <= 32'h0000_0000;
    end else if (ro_done) begin
      frames_ff <= frames_ff + 32'h0000_0001;
    end
  end

  // Read data stand one cycle, zero otherwise
  always_ff @(posedge CLK) begin
    if (RST) begin
      rdata_ff <= 32'h0000_0000;
    end else begin
      rdata_ff <= RD ? rd_mux : 32'h0000_0000;
    end
  end

  logic irq_ff;
  always_ff @(posedge CLK) begin
    if (RST) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  assign RDATA      = rdata_ff;
  assign TRIG_READY = stat_ff.trig_ready;
  assign EXPOSURE   = stat_ff.exposure;
  assign READOUT    = stat_ff.readout;
  assign IMAGING    = stat_ff.imaging;
  assign IDLE       = stat_ff.idle;
  assign IRQ        = irq_ff;

endmodule

// File: tb/ets_top_sva.sv
// Checker: port-level assertions for the exposure trigger sequencer
`timescale 1ns/1ps
module ets_top_chk
  import ets_pkg::*;
(
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic        TRIG_IN,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        TRIG_READY,
  input wire logic        EXPOSURE,
  input wire logic        READOUT,
  input wire logic        IMAGING,
  input wire logic        IDLE,
  input wire logic        IRQ
);
  // ==========================================================================
  // Helper: cycles since trigger-ready last fell
  logic       rdy_q_ff;
  logic [7:0] since_ff;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  always_ff @(posedge CLK) begin
    rdy_q_ff <= TRIG_READY;
    if (RST) since_ff <= 8'hFF;
    else if (rdy_q_ff && !TRIG_READY) since_ff <= 8'h00;
    else if (since_ff != 8'hFF) since_ff <= since_ff + 8'h01;
  end

  // ==========================================================================
  // Assertions
  a_imaging_either: assert property (IMAGING == (EXPOSURE || READOUT))
    else $error("imaging differs from exposure or readout");
  a_idle_inverse: assert property (IDLE != IMAGING)
    else $error("idle equals imaging");
  a_exp_launch_rd: assert property ($fell(EXPOSURE) |-> READOUT)
    else $error("exposure ended without readout");
  a_exp_min_len: assert property ($rose(EXPOSURE) |=> EXPOSURE [*8])
    else $error("exposure too short");
  a_ready_held_low: assert property ($rose(EXPOSURE) |-> !TRIG_READY [*8])
    else $error("ready back too early");
  a_accept_exp: assert property ($fell(TRIG_READY) |-> ##[0:130] $rose(EXPOSURE))
    else $error("accepted trigger gave no exposure");
  a_no_queue: assert property ($rose(EXPOSURE) |-> since_ff <= 8'h8C)
    else $error("exposure without recent accept");
  a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
    else $error("read data outside read cycle");

  c_overlap: cover property (EXPOSURE && READOUT);
  c_ready_in_rd: cover property ($rose(TRIG_READY) && READOUT);
  c_irq: cover property ($rose(IRQ));
endmodule

bind ets_top ets_top_chk u_chk (
  .CLK(CLK), .RST(RST), .TRIG_IN(TRIG_IN), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .TRIG_READY(TRIG_READY), .EXPOSURE(EXPOSURE),
  .READOUT(READOUT), .IMAGING(IMAGING), .IDLE(IDLE), .IRQ(IRQ)
);

// File: tb/ets_trig_src.sv
// Partner model: external trigger source on the trigger pin
`timescale 1ns/1ps
module ets_trig_src
  import ets_pkg::*;
#(
  parameter int WIDTH = 24
) (
  input  wire logic CLK,
  input  wire logic go,
  input  wire logic on_ready,
  input  wire logic trig_ready,
  output logic      trig
);
  // ==========================================================================
  // Pulse high WIDTH cycles, then low at least WIDTH+1 cycles
  int cnt = 0;

  always @(posedge CLK) begin
    if (cnt != 0) cnt <= cnt - 1;
    else if (go || (on_ready && trig_ready)) cnt <= 2 * WIDTH;
  end

  // Width is three times the roughly eight-cycle latency
  assign trig = (cnt > WIDTH);
endmodule

// File: tb/tb_ets_top.sv
// Testbench: trigger, overlap and register scenarios for the sequencer
`timescale 1ns/1ps
module tb_ets_top;
  import ets_pkg::*;
  // ==========================================================================
  // Signals and event logs
  logic        CLK, RST, TRIG_IN, WR, RD, TRIG_READY, EXPOSURE, READOUT, IMAGING, IDLE, IRQ;
  logic        go, on_rdy;
  logic [7:0]  ADDR;
  logic [31:0] WDATA, RDATA;
  int          miscompares = 0, num_checks = 0, cyc = 0;
  int          ne = 0, nf = 0, nr = 0, nrf = 0, ny = 0;
  int          er[16], ef[16], rr[16], rf[16], yr[16];

  ets_top DUT (.CLK(CLK), .RST(RST), .TRIG_IN(TRIG_IN), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .TRIG_READY(TRIG_READY), .EXPOSURE(EXPOSURE),
    .READOUT(READOUT), .IMAGING(IMAGING), .IDLE(IDLE), .IRQ(IRQ));
  ets_trig_src src (.CLK(CLK), .go(go), .on_ready(on_rdy), .trig_ready(TRIG_READY),
    .trig(TRIG_IN));

  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  always @(negedge CLK) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      conclude();
    end
  end
  always @(posedge EXPOSURE) if (!RST) begin
    er[ne] = cyc;
    ne++;
  end
  always @(negedge EXPOSURE) if (!RST) begin
    ef[nf] = cyc;
    nf++;
  end
  always @(posedge READOUT) if (!RST) begin
    rr[nr] = cyc;
    nr++;
  end
  always @(negedge READOUT) if (!RST) begin
    rf[nrf] = cyc;
    nrf++;
  end
  always @(posedge TRIG_READY) if (!RST) begin
    yr[ny] = cyc;
    ny++;
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rng(input int got, input int lo, input int hi);
    num_checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(RDATA, exp);
    @(posedge CLK);
  endtask
  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk({31'h0, IRQ}, {31'h0, exp});
    @(posedge CLK);
  endtask
  task automatic pulse_go();
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    RST = 1'b1;
    {WR, RD, go, on_rdy} = 4'h0;
    ADDR = 8'h00;
    WDATA = 32'h0000_0000;
    repeat (6) @(posedge CLK);
    RST <= 1'b0;
    @(posedge CLK);
    rdc(ETS_REG_EXPOSURE, ETS_EXPOSURE_RST);
    rdc(ETS_REG_ROWS, {16'h0000, ETS_ROWS_RST});
    rdc(ETS_REG_ROWTIME, {16'h0000, ETS_ROWTIME_RST});
    rdc(ETS_REG_IRQ_MASK, {28'h0000000, ETS_MASK_RST});
    rdc(8'h24, 32'h0000_0000);
    // Exposure 3 us, 5 rows of 4 us: readout 500 cycles, start delay 425
    wr(ETS_REG_EXPOSURE, 32'h0000_0003);
    wr(ETS_REG_ROWS, 32'h0000_0005);
    wr(ETS_REG_ROWTIME, 32'h0000_0004);
    wr(ETS_REG_IRQ_MASK, 32'h0000_000F);
    wr(ETS_REG_CTRL, 32'h0000_0001);
    while (TRIG_READY !== 1'b1) @(posedge CLK);
    rdc(ETS_REG_STATUS, 32'h0000_0003);
    pulse_go();
    while (EXPOSURE !== 1'b1) @(posedge CLK);
    rdc(ETS_REG_STATUS, 32'h0000_0014);
    on_rdy <= 1'b1;
    while (ne < 2) @(posedge CLK);
    on_rdy <= 1'b0;
    repeat (50) @(posedge CLK);
    pulse_go();
    while (IDLE !== 1'b1) @(posedge CLK);
    repeat (200) @(posedge CLK);
    chk(ne, 2);
    rdc(ETS_REG_FRAMES, 32'h0000_0002);
    rng(ef[0] - er[0], 50, 100);
    chk(rr[0], ef[0]);
    rng(yr[1] - er[0], 400, 450);
    rng((er[1] - rr[0] + 10) % 100, 0, 20);
    rng(er[1] - yr[1], 0, 130);
    rng(ef[1] - rr[0], 490, 530);
    rng(rf[nrf - 1] - ef[1], 475, 525);
    rdc(ETS_REG_IRQ_STAT, 32'h0000_000F);
    chk_irq(1'b1);
    wr(ETS_REG_IRQ_MASK, 32'h0000_0000);
    chk_irq(1'b0);
    wr(ETS_REG_IRQ_MASK, 32'h0000_000F);
    chk_irq(1'b1);
    wr(ETS_REG_IRQ_STAT, 32'h0000_000F);
    rdc(ETS_REG_IRQ_STAT, 32'h0000_0000);
    chk_irq(1'b0);
    conclude();
  end
endmodule
